// ---- design/fp_instruction_datapath.sv ----
`timescale 1ns/1ps
// Floating-point instruction datapath: register file, transfers, moves and traps
module fp_instruction_datapath (
    input wire logic i_clock,
    input wire logic i_reset_n,
    input wire fpx_pkg::fp_req_s i_req,
    input wire logic i_wide_register_mode_bit,
    input wire logic [1:0] i_rounding_mode_field,
    input wire logic [4:0] i_trap_enables,
    input wire logic [7:0] i_condition_codes,
    input wire logic i_trap_clear,
    input wire logic [63:0] i_mem_rdata,
    output fpx_pkg::mem_req_s o_mem,
    output fpx_pkg::gpr_wr_s o_gpr,
    output logic o_ready,
    output logic [4:0] o_cause,
    output logic o_unimplemented,
    output logic o_trap
);
    import fpx_pkg::*;

    // ****************
    // Register file
    // ****************
    logic [63:0] fpr_r [FPR_COUNT];

    // Reads one word, a wide register or an even/odd pair
    function automatic logic [63:0] f_rd(input logic [4:0] idx, input logic dbl, input logic wide);
        if (!dbl)
            f_rd = {32'h0, fpr_r[idx][31:0]};
        else if (wide)
            f_rd = fpr_r[idx];
        else
            f_rd = {fpr_r[{idx[4:1], 1'b1}][31:0], fpr_r[{idx[4:1], 1'b0}][31:0]};
    endfunction

    logic ready_r, halt_r, halt_nxt, load_pend_r, load_dbl_r;
    logic [4:0] load_idx_r, cause_r;
    logic unimpl_r;
    mem_req_s mem_r, mem_nxt;
    gpr_wr_s gpr_r, gpr_nxt;
    logic accept, is_mem, is_store, is_dbl_mem, is_arith, fused, dbl, rd_dbl, cc_hit, trap_now;
    logic [63:0] disp_ext, src_a, src_b, src_c;
    logic wr_en, wr_dbl;
    logic [4:0] wr_idx;
    logic [63:0] wr_data;
    alu_res_s res;

    // ****************
    // Decode and operand fetch
    // ****************
    always_comb begin
        accept = i_req.valid & ready_r;
        is_mem = (i_req.op[4:3] == 2'h0);
        is_store = i_req.op[1];
        is_dbl_mem = i_req.op[0];
        is_arith = i_req.op[4];
        fused = (i_req.op inside {OP_MADD, OP_MSUB, OP_NMADD, OP_NMSUB});
        dbl = (i_req.fmt == FMT_DOUBLE);
        cc_hit = (i_condition_codes[i_req.condition_code_select] == i_req.move_on_true);
        disp_ext = {{48{i_req.disp[15]}}, i_req.disp};
        case (i_req.op)
            OP_CVT: rd_dbl = i_req.src_fmt[0];
            OP_MOVE_FPR_TO_GPR_64: rd_dbl = 1'b1;
            // Word moves read one register, odd ones too
            OP_MOVE_FPR_TO_GPR_32, OP_MOVE_GPR_TO_FPR_32: rd_dbl = 1'b0;
            default: rd_dbl = is_mem ? is_dbl_mem : dbl;
        endcase
        src_a = f_rd(fused ? i_req.fr : i_req.fs, rd_dbl, i_wide_register_mode_bit);
        src_b = f_rd(fused ? i_req.fs : i_req.ft, dbl, i_wide_register_mode_bit);
        src_c = f_rd(i_req.ft, dbl, i_wide_register_mode_bit);
        // Unhandled operands or enabled cause trap
        trap_now = accept & is_arith & (res.unimpl | (|(res.cause & i_trap_enables)));
    end

    // Arithmetic, sign and conversion unit
    fp_exec_unit u_exec (
        .i_op(i_req.op),
        .i_fmt(i_req.fmt),
        .i_src_fmt(i_req.src_fmt),
        .i_rounding_mode_field(i_rounding_mode_field),
        .i_a(src_a),
        .i_b(src_b),
        .i_c(src_c),
        .o_res(res)
    );

    // ****************
    // Result routing
    // ****************
    always_comb begin
        wr_en = 1'b0;
        wr_dbl = dbl;
        wr_idx = i_req.fd;
        wr_data = src_a;
        mem_nxt = '0;
        gpr_nxt = '0;
        gpr_nxt.idx = i_req.gpr_dest;
        if (load_pend_r) begin
            // Raw memory word into the register
            wr_en = 1'b1;
            wr_dbl = load_dbl_r;
            wr_idx = load_idx_r;
            wr_data = i_mem_rdata;
        end else if (accept) begin
            if (is_mem) begin
                mem_nxt.read = !is_store;
                mem_nxt.write = is_store;
                mem_nxt.dbl = is_dbl_mem;
                mem_nxt.addr = i_req.base + (i_req.op[2] ? i_req.index : disp_ext);
                mem_nxt.wdata = src_a;
            end else begin
                case (i_req.op)
                    OP_MOVE_GPR_TO_FPR_32, OP_MOVE_GPR_TO_FPR_64: begin
                        wr_en = 1'b1;
                        wr_dbl = i_req.op[0];
                        wr_data = i_req.base;
                    end
                    OP_MOVE_FPR_TO_GPR_32: begin
                        gpr_nxt.we = 1'b1;
                        gpr_nxt.data = {{32{src_a[31]}}, src_a[31:0]};
                    end
                    OP_MOVE_FPR_TO_GPR_64: begin
                        gpr_nxt.we = 1'b1;
                        gpr_nxt.data = src_a;
                    end
                    OP_MOVE_COND_GPR: begin
                        gpr_nxt.we = cc_hit;
                        gpr_nxt.data = i_req.base;
                    end
                    OP_MOVE_FPR: wr_en = 1'b1;
                    OP_MOVE_COND_FPR: wr_en = cc_hit;
                    default: begin
                        wr_en = !trap_now;
                        wr_dbl = i_req.fmt[0];
                        wr_data = res.value;
                    end
                endcase
            end
        end
    end

    // Wide register, even/odd pair or single word
    always_ff @(posedge i_clock) begin
        if (wr_en) begin
            if (!wr_dbl)
                fpr_r[wr_idx][31:0] <= wr_data[31:0];
            else if (i_wide_register_mode_bit)
                fpr_r[wr_idx] <= wr_data;
            else begin
                fpr_r[{wr_idx[4:1], 1'b0}][31:0] <= wr_data[31:0];
                fpr_r[{wr_idx[4:1], 1'b1}][31:0] <= wr_data[63:32];
            end
        end
    end

    // ****************
    // Sequencing
    // ****************
    // Load data lands one clock after the request
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            load_pend_r <= 1'b0;
            load_idx_r <= 5'h00;
            load_dbl_r <= 1'b0;
        end else begin
            load_pend_r <= accept & is_mem & !is_store;
            load_idx_r <= i_req.fd;
            load_dbl_r <= is_dbl_mem;
        end
    end

    // Memory and general register outputs
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            mem_r <= '0;
            gpr_r <= '0;
        end else begin
            mem_r <= mem_nxt;
            gpr_r <= gpr_nxt;
        end
    end

    // Exception state of the last arithmetic operation
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            cause_r <= 5'h00;
            unimpl_r <= 1'b0;
        end else if (accept & is_arith) begin
            cause_r <= res.cause;
            unimpl_r <= res.unimpl;
        end
    end

    // Halt until the trap is cleared
    always_comb begin
        halt_nxt = trap_now | (halt_r & !i_trap_clear);
    end

    // Halt and ready flags
    always_ff @(posedge i_clock) begin
        if (!i_reset_n) begin
            halt_r <= 1'b0;
            ready_r <= 1'b0;
        end else begin
            halt_r <= halt_nxt;
            ready_r <= !halt_nxt & !(accept & is_mem & !is_store);
        end
    end

    assign o_mem = mem_r;
    assign o_gpr = gpr_r;
    assign o_ready = ready_r;
    assign o_cause = cause_r;
    assign o_unimplemented = unimpl_r;
    assign o_trap = halt_r;

    // ****************
    // Assertions
    // ****************
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_reset_n);

    AST_MEM_NO_EXC:
        assert property (accept && is_mem |=> !o_trap && o_cause == $past(o_cause))
        else $error("transfer changed exception state");
    AST_LOAD_DATA:
        assert property (load_pend_r && !load_dbl_r |=> fpr_r[$past(load_idx_r)][31:0] == $past(i_mem_rdata[31:0]))
        else $error("loaded word not in register");
    AST_ADDRESS:
        assert property (accept && is_mem |=> o_mem.addr == $past(i_req.base)
                         + ($past(i_req.op[2]) ? $past(i_req.index) : $past(disp_ext)))
        else $error("wrong transfer address");
    AST_MOVE_BITS:
        assert property (accept && i_req.op == OP_MOVE_FPR_TO_GPR_64 |=> o_gpr.we && o_gpr.data == $past(src_a))
        else $error("move altered bits");
    AST_COND_MOVE:
        assert property (accept && i_req.op == OP_MOVE_COND_GPR
                         |=> o_gpr.we == $past(cc_hit) && o_gpr.data == $past(i_req.base))
        else $error("conditional move wrong");
    AST_PAIR_WRITE:
        assert property (wr_en && wr_dbl && !i_wide_register_mode_bit
                         |=> fpr_r[{$past(wr_idx[4:1]), 1'b1}][31:0] == $past(wr_data[63:32]))
        else $error("odd half of pair wrong");
    AST_UNIMP_TRAP:
        assert property (accept && is_arith && res.unimpl |=> o_trap && o_unimplemented && !o_ready)
        else $error("unimplemented trap missing");
    AST_SIGN_ONLY:
        assert property (accept && i_req.op == OP_NEG && !dbl && !trap_now
                         |=> fpr_r[$past(i_req.fd)][31:0] == ({1'b1, 31'h0} ^ $past(src_a[31:0])))
        else $error("negate changed more than sign");
    AST_ROUND_ZERO:
        assert property (accept && i_req.op == OP_CVT && i_req.fmt == FMT_SINGLE && i_req.src_fmt == FMT_DOUBLE
                         && i_rounding_mode_field == RM_ZERO && !trap_now
                         |=> fpr_r[$past(i_req.fd)][22:0] == $past(src_a[51:29]))
        else $error("toward-zero narrowing rounded up");
    AST_TRAP_HOLDS:
        assert property (trap_now ##1 !i_trap_clear |=> o_trap && !o_ready)
        else $error("trap released without clear");

    COV_LOAD: cover property (accept && is_mem && !is_store ##1 load_pend_r);
    COV_TRAP: cover property (trap_now ##1 o_trap);
    COV_COND_SKIP: cover property (accept && i_req.op == OP_MOVE_COND_FPR && !cc_hit);
    COV_PAIR: cover property (wr_en && wr_dbl && !i_wide_register_mode_bit);
endmodule // fp_instruction_datapath

// ---- inc/fpx_pkg.sv ----
// Shared types and constants of the floating-point instruction datapath
//
// Summary of operation
// - Loads and stores move raw words, no exceptions
// - Odd-numbered FP registers allowed for transfers
// - Address: base plus displacement or index
// - Register moves copy bits, never raise exceptions
// - Conditional integer move obeys selected condition
// - Double move uses pair or wide register
// - Unhandled operands raise unimplemented-operation trap
// - One format, single or double, per operation
// - Four fused multiply-add forms
// - Abs clears sign and negate flips it; signalling NaN invalid
// - Conversions round per current rounding mode
// - Conversions among single, double, word, long
// - Rounding field: nearest, zero, plus, minus
package fpx_pkg;
    // ****************
    // Sizes and timing
    // ****************
    localparam int FPR_COUNT = 32;
    localparam int LOAD_DELAY_CLOCKS = 1;

    // ****************
    // Rounding modes and exception bits
    // ****************
    localparam logic [1:0] RM_NEAREST = 2'h0;
    localparam logic [1:0] RM_ZERO = 2'h1;
    localparam logic [1:0] RM_PLUS = 2'h2;
    localparam logic [1:0] RM_MINUS = 2'h3;
    localparam int EXC_INVALID = 4;
    localparam int EXC_DIVZERO = 3;
    localparam int EXC_OVERFLOW = 2;
    localparam int EXC_UNDERFLOW = 1;
    localparam int EXC_INEXACT = 0;

    // ****************
    // Number encodings
    // ****************
    localparam logic [10:0] EXP_REBIAS = 11'h380;
    localparam logic [10:0] S_EXP_TOP = 11'h0FE;
    localparam logic [63:0] D_INF = 64'h7FF0_0000_0000_0000;
    localparam logic [63:0] S_INF = 64'h0000_0000_7F80_0000;
    localparam logic [63:0] D_QNAN = 64'h7FF8_0000_0000_0000;
    localparam logic [63:0] S_QNAN = 64'h0000_0000_7FC0_0000;

    // ****************
    // Operations and formats
    // ****************
    typedef enum logic [4:0] {
        OP_LOAD_WORD_FP = 5'h00,
        OP_LOAD_DOUBLE_WORD_FP = 5'h01,
        OP_STORE_WORD_FP = 5'h02,
        OP_STORE_DOUBLE_WORD_FP = 5'h03,
        OP_LOAD_WORD_INDEXED_FP = 5'h04,
        OP_LOAD_DOUBLE_INDEXED_FP = 5'h05,
        OP_STORE_WORD_INDEXED_FP = 5'h06,
        OP_STORE_DOUBLE_INDEXED_FP = 5'h07,
        OP_MOVE_GPR_TO_FPR_32 = 5'h08,
        OP_MOVE_GPR_TO_FPR_64 = 5'h09,
        OP_MOVE_FPR_TO_GPR_32 = 5'h0A,
        OP_MOVE_FPR_TO_GPR_64 = 5'h0B,
        OP_MOVE_COND_GPR = 5'h0C,
        OP_MOVE_FPR = 5'h0D,
        OP_MOVE_COND_FPR = 5'h0E,
        OP_ADD = 5'h10,
        OP_SUB = 5'h11,
        OP_MUL = 5'h12,
        OP_DIV = 5'h13,
        OP_MADD = 5'h14,
        OP_MSUB = 5'h15,
        OP_NMADD = 5'h16,
        OP_NMSUB = 5'h17,
        OP_ABS = 5'h18,
        OP_NEG = 5'h19,
        OP_CVT = 5'h1A
    } fp_op_e;

    typedef enum logic [1:0] {
        FMT_SINGLE = 2'h0,
        FMT_DOUBLE = 2'h1,
        FMT_WORD = 2'h2,
        FMT_LONG = 2'h3
    } fmt_e;

    // ****************
    // Carriers
    // ****************
    typedef struct packed {
        logic valid;
        fp_op_e op;
        fmt_e fmt;
        fmt_e src_fmt;
        logic [4:0] fd;
        logic [4:0] fs;
        logic [4:0] ft;
        logic [4:0] fr;
        logic [4:0] gpr_dest;
        logic [2:0] condition_code_select;
        logic move_on_true;
        logic [63:0] base;
        logic [63:0] index;
        logic [15:0] disp;
    } fp_req_s;

    typedef struct packed {
        logic read;
        logic write;
        logic dbl;
        logic [63:0] addr;
        logic [63:0] wdata;
    } mem_req_s;

    typedef struct packed {
        logic we;
        logic [4:0] idx;
        logic [63:0] data;
    } gpr_wr_s;

    typedef struct packed {
        logic [63:0] value;
        logic [4:0] cause;
        logic unimpl;
    } alu_res_s;
endpackage

// ---- design/fp_exec_unit.sv ----
`timescale 1ns/1ps
// Combinational special-case arithmetic, sign and conversion unit
module fp_exec_unit (
    input wire fpx_pkg::fp_op_e i_op,
    input wire fpx_pkg::fmt_e i_fmt,
    input wire fpx_pkg::fmt_e i_src_fmt,
    input wire logic [1:0] i_rounding_mode_field,
    input wire logic [63:0] i_a,
    input wire logic [63:0] i_b,
    input wire logic [63:0] i_c,
    output fpx_pkg::alu_res_s o_res
);
    import fpx_pkg::*;

    // ****************
    // Field helpers
    // ****************
    function automatic logic f_sign(input logic [63:0] x, input logic dbl);
        f_sign = dbl ? x[63] : x[31];
    endfunction

    function automatic logic f_zero(input logic [63:0] x, input logic dbl);
        f_zero = dbl ? (x[62:0] == 63'h0) : (x[30:0] == 31'h0);
    endfunction

    // Infinity, NaN or denormal: handed to the software emulator
    function automatic logic f_odd(input logic [63:0] x, input logic dbl);
        f_odd = dbl ? (&x[62:52] | (~|x[62:52] & |x[51:0]))
                    : (&x[30:23] | (~|x[30:23] & |x[22:0]));
    endfunction

    function automatic logic f_snan(input logic [63:0] x, input logic dbl);
        f_snan = dbl ? (&x[62:52] & !x[51] & |x[50:0]) : (&x[30:23] & !x[22] & |x[21:0]);
    endfunction

    function automatic logic [63:0] f_signed(input logic [63:0] x, input logic dbl, input logic s);
        f_signed = dbl ? {s, x[62:0]} : {32'h0, s, x[30:0]};
    endfunction

    // Sign of an exact zero sum
    function automatic logic f_zsum(input logic x, input logic y, input logic [1:0] rm);
        f_zsum = (x & y) | ((x ^ y) & (rm == RM_MINUS));
    endfunction

    logic dbl, src_dbl, sa, sb, sc, st, zsrc, in_range, guard, sticky, round_up;
    logic [10:0] exp_d;
    logic [30:0] narrow, narrow_rnd;
    alu_res_s res;

    always_comb begin
        exp_d = i_a[62:52];
        narrow = {8'(exp_d - EXP_REBIAS), i_a[51:29]};
        guard = i_a[28];
        sticky = |i_a[27:0];
        in_range = (exp_d > EXP_REBIAS) && (exp_d <= EXP_REBIAS + S_EXP_TOP);
        case (i_rounding_mode_field)
            RM_NEAREST: round_up = guard & (sticky | narrow[0]);
            RM_ZERO: round_up = 1'b0;
            RM_PLUS: round_up = !i_a[63] & (guard | sticky);
            RM_MINUS: round_up = i_a[63] & (guard | sticky);
            default: round_up = 1'b0;
        endcase
        narrow_rnd = narrow + 31'(round_up);
    end

    // Operation select
    always_comb begin
        dbl = (i_fmt == FMT_DOUBLE);
        src_dbl = (i_src_fmt == FMT_DOUBLE);
        sa = f_sign(i_a, dbl);
        sb = f_sign(i_b, dbl) ^ (i_op == OP_SUB);
        sc = f_sign(i_c, dbl);
        st = sa ^ (i_op inside {OP_MSUB, OP_NMSUB});
        zsrc = i_src_fmt[1] ? (i_src_fmt[0] ? (i_a == 64'h0) : (i_a[31:0] == 32'h0))
                            : f_zero(i_a, i_src_fmt[0]);
        res = '0;
        case (i_op)
            OP_ADD, OP_SUB: begin
                if (f_odd(i_a, dbl) | f_odd(i_b, dbl))
                    res.unimpl = 1'b1;
                else if (f_zero(i_a, dbl) & f_zero(i_b, dbl))
                    res.value = f_signed(64'h0, dbl, f_zsum(sa, sb, i_rounding_mode_field));
                else if (f_zero(i_b, dbl))
                    res.value = i_a;
                else if (f_zero(i_a, dbl))
                    res.value = f_signed(i_b, dbl, sb);
                else
                    res.unimpl = 1'b1;
            end
            OP_MUL: begin
                res.unimpl = f_odd(i_a, dbl) | f_odd(i_b, dbl) | !(f_zero(i_a, dbl) | f_zero(i_b, dbl));
                res.value = f_signed(64'h0, dbl, sa ^ sb);
            end
            OP_DIV: begin
                if (f_odd(i_a, dbl) | f_odd(i_b, dbl) | !(f_zero(i_a, dbl) | f_zero(i_b, dbl)))
                    res.unimpl = 1'b1;
                else if (f_zero(i_a, dbl) & f_zero(i_b, dbl)) begin
                    res.cause[EXC_INVALID] = 1'b1;
                    res.value = dbl ? D_QNAN : S_QNAN;
                end else if (f_zero(i_b, dbl)) begin
                    res.cause[EXC_DIVZERO] = 1'b1;
                    res.value = f_signed(dbl ? D_INF : S_INF, dbl, sa ^ sb);
                end else
                    res.value = f_signed(64'h0, dbl, sa ^ sb);
            end
            OP_MADD, OP_MSUB, OP_NMADD, OP_NMSUB: begin
                if (f_odd(i_a, dbl) | f_odd(i_b, dbl) | f_odd(i_c, dbl) | !(f_zero(i_b, dbl) | f_zero(i_c, dbl)))
                    res.unimpl = 1'b1;
                else if (f_zero(i_a, dbl))
                    res.value = f_signed(64'h0, dbl, f_zsum(f_sign(i_b, dbl) ^ sc, st, i_rounding_mode_field));
                else
                    res.value = f_signed(i_a, dbl, st);
                if (i_op inside {OP_NMADD, OP_NMSUB})
                    res.value = f_signed(res.value, dbl, !f_sign(res.value, dbl));
            end
            OP_ABS, OP_NEG: begin
                res.value = f_signed(i_a, dbl, (i_op == OP_NEG) & !sa);
                res.cause[EXC_INVALID] = f_snan(i_a, dbl);
            end
            OP_CVT: begin
                if (i_src_fmt[1] | i_fmt[1] | (i_fmt == i_src_fmt))
                    res.unimpl = !(i_src_fmt[1] ^ i_fmt[1]) | !zsrc;
                else if (f_odd(i_a, src_dbl))
                    res.unimpl = 1'b1;
                else if (zsrc)
                    res.value = f_signed(64'h0, dbl, f_sign(i_a, src_dbl));
                else if (src_dbl) begin
                    res.unimpl = !in_range | (&narrow_rnd[30:23]);
                    res.value = {32'h0, i_a[63], narrow_rnd};
                    res.cause[EXC_INEXACT] = guard | sticky;
                end else
                    res.value = {i_a[31], 11'(i_a[30:23]) + EXP_REBIAS, i_a[22:0], 29'h0};
            end
            default: res.unimpl = 1'b1;
        endcase
    end

    assign o_res = res;
endmodule // fp_exec_unit

// ---- verification/fp_mem_model.sv ----
`timescale 1ns/1ps
// Memory-path model that answers the datapath's loads and stores
module fp_mem_model (
    input wire logic i_clock,
    input wire fpx_pkg::mem_req_s i_mem,
    output logic [63:0] o_rdata
);
    import fpx_pkg::*;
    logic [63:0] mem_r [16];
    logic [63:0] last_r = 64'h0;
    always @(posedge i_clock) begin
        if (i_mem.write) begin
            mem_r[i_mem.addr[6:3]] <= i_mem.wdata;
        end
        if (i_mem.read) begin
            last_r <= o_rdata;
        end
    end
    // Data only in the read cycle, else a changed pattern
    assign o_rdata = i_mem.read ? mem_r[i_mem.addr[6:3]] : ~last_r;
endmodule // fp_mem_model

// ---- verification/tb_fp_instruction_datapath.sv ----
`timescale 1ns/1ps
// Self-checking bench of the floating-point instruction datapath
module tb_fp_instruction_datapath;
    import fpx_pkg::*;
    logic clk;
    logic rst_n = 1'b0;
    logic tc = 1'b0;
    logic [4:0] en = 5'h00;
    logic [7:0] cc = 8'h00;
    logic wide = 1'b1;
    logic [1:0] rm = 2'h0;
    logic [63:0] rd;
    logic [31:0] seed = 32'hC75E;
    fp_req_s r = '0;
    mem_req_s m;
    gpr_wr_s g;
    logic rdy;
    logic unimp;
    logic trap;
    logic [4:0] cause;
    int n_fail = 0;
    int checks_done = 0;
    fp_instruction_datapath dut_u (.i_clock(clk), .i_reset_n(rst_n), .i_req(r), .i_wide_register_mode_bit(wide),
        .i_rounding_mode_field(rm), .i_trap_enables(en), .i_condition_codes(cc), .i_trap_clear(tc),
        .i_mem_rdata(rd), .o_mem(m), .o_gpr(g), .o_ready(rdy), .o_cause(cause), .o_unimplemented(unimp),
        .o_trap(trap));
    fp_mem_model mem_u (.i_clock(clk), .i_mem(m), .o_rdata(rd));
    // Bench random source
    function automatic logic [63:0] rnd();
        logic [63:0] v;
        for (int k = 0; k < 64; k++) begin
            seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
            v = {v[62:0], seed[0]};
        end
        return v;
    endfunction
    function automatic logic [63:0] ea(logic [63:0] b, logic [15:0] d);
        return b + {{48{d[15]}}, d};
    endfunction
    task automatic finish_test();
        $display("checks %0d fails %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %0t saw %h expected %h", $time, s, e);
        end
    endtask
    // Issue one request once ready, at falling edges
    task automatic go(input fp_op_e op, input logic [4:0] d, input logic [4:0] s, input logic [4:0] t);
        int k;
        for (k = 0; k < 20 && rdy !== 1'b1; k++) @(negedge clk);
        if (k == 20) begin
            chk(64'h0, 64'h1);
            finish_test();
        end
        r.op = op;
        r.fd = d;
        r.fs = s;
        r.ft = t;
        r.valid = 1'b1;
        @(negedge clk);
        r.valid = 1'b0;
    endtask
    task automatic wr(input logic [4:0] d, input logic [63:0] v);
        r.base = v;
        go(OP_MOVE_GPR_TO_FPR_64, d, 5'h00, 5'h00);
    endtask
    task automatic rdf(input fp_op_e op, input logic [4:0] s, input logic [63:0] e);
        go(op, 5'h00, s, 5'h00);
        chk(g.data, e);
    endtask
    task automatic clr();
        tc = 1'b1;
        @(negedge clk);
        chk(trap, 1'b0);
        tc = 1'b0;
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ****************
    // Main sequence
    // ****************
    initial begin
        logic [63:0] v;
        logic [63:0] x;
        repeat (8) @(negedge clk);
        rst_n = 1'b1;
        cc = 8'(rnd());
        r.fmt = FMT_DOUBLE;
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            wr(5'(2 * i + 1), v);
            rdf(OP_MOVE_FPR_TO_GPR_64, 5'(2 * i + 1), v);
        end
        $display("test moves done");
        v = rnd();
        wr(5'h03, v);
        r.base = 64'h100;
        r.disp = 16'hFFF8;
        go(OP_STORE_DOUBLE_WORD_FP, 5'h00, 5'h03, 5'h00);
        chk(m.addr, ea(64'h100, 16'hFFF8));
        chk(m.wdata, v);
        r.base = 64'hF0;
        r.index = 64'h8;
        go(OP_LOAD_WORD_INDEXED_FP, 5'h04, 5'h00, 5'h00);
        chk(m.addr, 64'hF8);
        // Unrelated moves separate the load from its use
        for (int i = 0; i < 16; i++) begin
            r.condition_code_select = 3'(i);
            r.move_on_true = i[3];
            r.gpr_dest = 5'(i);
            r.base = rnd();
            go(OP_MOVE_COND_GPR, 5'h00, 5'h00, 5'h00);
            chk(g.we, cc[i[2:0]] == i[3]);
            if (g.we === 1'b1) chk(g.data, r.base);
        end
        rdf(OP_MOVE_FPR_TO_GPR_32, 5'h04, {{32{v[31]}}, v[31:0]});
        $display("test transfers done");
        v = rnd();
        v[62] = 1'b0;
        wr(5'h06, v);
        go(OP_ABS, 5'h07, 5'h06, 5'h00);
        chk(cause, 5'h00);
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h07, {1'b0, v[62:0]});
        go(OP_NEG, 5'h07, 5'h06, 5'h00);
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h07, {~v[63], v[62:0]});
        en = 5'h10;
        wr(5'h06, D_INF | 64'h1);
        go(OP_NEG, 5'h07, 5'h06, 5'h00);
        chk({trap, cause[EXC_INVALID]}, 2'b11);
        clr();
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h07, {~v[63], v[62:0]});
        $display("test sign ops done");
        en = 5'h08;
        x = rnd();
        x[62] = 1'b0;
        x[52] = 1'b1;
        wr(5'h08, x);
        wr(5'h09, 64'h0);
        go(OP_DIV, 5'h07, 5'h08, 5'h09);
        chk({trap, cause[EXC_DIVZERO]}, 2'b11);
        clr();
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h07, {~v[63], v[62:0]});
        en = 5'h00;
        go(OP_DIV, 5'h0B, 5'h08, 5'h09);
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h0B, D_INF | {x[63], 63'h0});
        go(OP_MUL, 5'h0B, 5'h08, 5'h09);
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h0B, {x[63], 63'h0});
        r.fr = 5'h08;
        for (int i = 0; i < 4; i++) begin
            go(fp_op_e'(5'h14 + i), 5'h0C, 5'h09, 5'h08);
            rdf(OP_MOVE_FPR_TO_GPR_64, 5'h0C, {x[63] ^ (i == 1 || i == 2), x[62:0]});
        end
        r.condition_code_select = 3'h0;
        for (int i = 0; i < 2; i++) begin
            r.move_on_true = cc[0] ^ i[0];
            go(OP_MOVE_COND_FPR, 5'h0D, 5'(8 + i), 5'h00);
        end
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h0D, x);
        go(OP_ADD, 5'h0D, 5'h08, 5'h08);
        chk({trap, unimp}, 2'b11);
        clr();
        $display("test arithmetic done");
        v = rnd();
        x = {12'h3FF, 1'b0, v[50:1], 1'b1};
        wr(5'h0E, x);
        r.fmt = FMT_SINGLE;
        r.src_fmt = FMT_DOUBLE;
        for (int i = 0; i < 2; i++) begin
            rm = i[0] ? RM_PLUS : RM_ZERO;
            go(OP_CVT, 5'h0F, 5'h0E, 5'h00);
            chk(cause, 5'h01);
            rdf(OP_MOVE_FPR_TO_GPR_32, 5'h0F, {41'h7F, x[51:29]} + 64'(i));
        end
        go(OP_NEG, 5'h0F, 5'h0F, 5'h00);
        rdf(OP_MOVE_FPR_TO_GPR_32, 5'h0F, {33'h1_FFFF_FFFF, 8'h7F, x[51:29]} + 64'h1);
        r.fmt = FMT_DOUBLE;
        wide = 1'b0;
        v = rnd();
        wr(5'h10, v);
        rdf(OP_MOVE_FPR_TO_GPR_32, 5'h11, {{32{v[63]}}, v[63:32]});
        rdf(OP_MOVE_FPR_TO_GPR_64, 5'h11, v);
        $display("test conversions done");
        finish_test();
    end
endmodule // tb_fp_instruction_datapath
